// ===== rtl/ctg_map.svh
// register map, field positions, reset values and codes of the port tx clock generator
`ifndef CTG_MAP_SVH
`define CTG_MAP_SVH

// clock
`define CTG_MCLK_PERIOD_NS  10

// register indices; the byte address is four times the index
`define CTG_IDX_IRQ2_EN     12'h21a
`define CTG_IDX_TXA_GEN     12'h220
`define CTG_IDX_STATUS      12'h230

// reset values
`define CTG_RST_IRQ2_EN     16'h0000
`define CTG_RST_TXA_GEN     16'h0403

// clock generation fields
`define CTG_DIV_MSB         5
`define CTG_DIV_LSB         0
`define CTG_LOAD_BIT        6
`define CTG_INV_BIT         7
`define CTG_SRC_MSB         10
`define CTG_SRC_LSB         8
`define CTG_OE_BIT          11
`define CTG_PRESENT_BIT     12
`define CTG_RUN_BIT         13
`define CTG_RSVD_MASK       16'h3fff

// source codes
`define CTG_SRC_TX_A        3'h0
`define CTG_SRC_TX_B        3'h1
`define CTG_SRC_TX_C        3'h2
`define CTG_SRC_RX_A        3'h3
`define CTG_SRC_RX_B        3'h4
`define CTG_SRC_RX_C        3'h5
`define CTG_SRC_MEM         3'h6
`define CTG_NUM_SRC         7

// bus widths and responses
`define CTG_ADDR_W          14
`define CTG_RESP_OKAY       2'h0
`define CTG_RESP_SLVERR     2'h2

`endif

// ===== rtl/ctg_pkg.sv
// types shared by the port tx clock generator
package ctg_pkg;

  // axi4-lite signals driven by the master
  typedef struct packed {
    logic [13:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [13:0] araddr;
    logic        arvalid;
    logic        rready;
  } ctg_axi_req_t;

  // axi4-lite signals driven by this slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ctg_axi_rsp_t;

  // clock generation register layout, msb first
  typedef struct packed {
    logic [1:0]  rsvd;
    logic        div_run;
    logic        present;
    logic        oe;
    logic [2:0]  src;
    logic        inv;
    logic        load_now;
    logic [5:0]  div;
  } ctg_clkgen_t;

endpackage

// ===== rtl/ctg_divider.sv
// edge-counting divider for the port tx clock
`timescale 1ns/1ps
`default_nettype none
module ctg_divider #(
  parameter int DIV_W = 6
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // control
  input  wire logic             run,
  input  wire logic             load_now,
  input  wire logic [DIV_W-1:0] div_new,
  // selected source, already synchronised
  input  wire logic             src_level,
  input  wire logic             src_rise,
  input  wire logic             src_fall,
  // result
  output logic                  clk_level,
  output logic [DIV_W-1:0]      active_div,
  output logic                  waiting
);

  logic [DIV_W:0]   cnt;
  logic [DIV_W-1:0] eff;
  logic [DIV_W:0]   last;
  logic             bypass;

  // zero and one both mean the source itself
  assign bypass = (active_div <= DIV_W'(1));
  assign eff    = bypass ? DIV_W'(1) : active_div;
  // one period spans two edges per source period
  assign last   = (DIV_W+1)'({eff, 1'b0} - 1'b1);

  // counter over both source edges; cnt 0 always falls on a rising edge
  always_ff @(posedge mclk) begin
    if (!rstn || !run) begin
      cnt        <= '0;
      active_div <= div_new;
      waiting    <= 1'b1;
    end else if (load_now) begin
      // restart mid-period: the output may show a runt pulse
      cnt        <= '0;
      active_div <= div_new;
      waiting    <= 1'b1;
    end else if (waiting) begin
      if (src_rise) begin
        cnt        <= '0;
        active_div <= div_new;
        waiting    <= 1'b0;
      end
    end else if (src_rise || src_fall) begin
      if (cnt == last) begin
        // period boundary, the only point outside a load or restart where a new divisor is taken
        cnt        <= '0;
        active_div <= div_new;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // high for eff edges out of 2*eff: odd values carry the source's uneven halves
  always_comb begin
    if (waiting) begin
      clk_level = 1'b0;
    end else if (bypass) begin
      clk_level = src_level;
    end else begin
      clk_level = (cnt < {1'b0, eff});
    end
  end

endmodule
`default_nettype wire

// ===== rtl/ctg_clock_gen.sv
// port tx clock generator: axi4-lite registers, source selection and pin drive
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ctg_map.svh"
module ctg_clock_gen #(
  parameter int NUM_SRC = `CTG_NUM_SRC,
  parameter int DIV_W   = 6
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // register bus
  input  wire ctg_pkg::ctg_axi_req_t axi_req,
  output var  ctg_pkg::ctg_axi_rsp_t axi_rsp,
  // candidate sources: tx a-c, rx a-c, memory clock
  input  wire logic [NUM_SRC-1:0]    source_pins,
  // port tx clock pin
  output logic                       tx_clk_out,
  output logic                       tx_clk_oe
);
  import ctg_pkg::*;

  localparam int AW = `CTG_ADDR_W;

  // register state
  ctg_clkgen_t      gen;
  logic [15:0]      irq2_en;
  logic             load_pulse;

  // write channel state
  logic             aw_held;
  logic             w_held;
  logic [AW-1:0]    aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             bvalid;
  logic [1:0]       bresp;
  logic             wr_fire;
  logic [AW-3:0]    wr_idx;
  logic             wr_irq2;
  logic             wr_gen;

  // read channel state
  logic             rvalid;
  logic [31:0]      rdata;
  logic [1:0]       rresp;
  logic             rd_fire;
  logic [AW-3:0]    rd_idx;

  // source path
  logic [NUM_SRC-1:0] sync_a;
  logic [NUM_SRC-1:0] sync_b;
  logic [NUM_SRC-1:0] sync_c;
  logic             sel_ok;
  logic             sel_now;
  logic             sel_prev;
  logic             src_rise;
  logic             src_fall;

  // divider results
  logic             div_clk;
  logic [DIV_W-1:0] active_div;
  logic             div_waiting;
  logic [31:0]      status_word;

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ---------------- write channel ----------------

  // address and data are taken independently, in either order
  assign axi_rsp.awready = !aw_held && !bvalid;
  assign axi_rsp.wready  = !w_held && !bvalid;
  assign axi_rsp.bvalid  = bvalid;
  assign axi_rsp.bresp   = bresp;

  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx  = aw_addr[AW-1:2];
  assign wr_irq2 = wr_fire && (wr_idx == `CTG_IDX_IRQ2_EN);
  assign wr_gen  = wr_fire && (wr_idx == `CTG_IDX_TXA_GEN);

  // hold the write address until the data has also arrived
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (axi_req.awvalid && axi_rsp.awready) begin
      aw_held <= 1'b1;
      aw_addr <= axi_req.awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // hold the write data until the address has also arrived
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (axi_req.wvalid && axi_rsp.wready) begin
      w_held <= 1'b1;
      w_data <= axi_req.wdata;
      w_strb <= axi_req.wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // write response; the read-only status word and holes answer slverr
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= `CTG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (wr_irq2 || wr_gen) ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------- registers ----------------

  // interrupt source enables: plain storage, all 16 bits kept
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq2_en <= `CTG_RST_IRQ2_EN;
    end else if (wr_irq2) begin
      irq2_en <= lane_merge(irq2_en, w_data, w_strb);
    end
  end

  // clock generation register; the load bit and reserved bits are never stored
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gen <= ctg_clkgen_t'(`CTG_RST_TXA_GEN);
    end else if (wr_gen) begin
      gen <= ctg_clkgen_t'(lane_merge(16'(gen), w_data, w_strb)
                           & `CTG_RSVD_MASK
                           & ~(16'h0001 << `CTG_LOAD_BIT));
    end
  end

  // self-clearing immediate load: a single-cycle pulse into the divider
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= wr_gen && w_strb[0] && w_data[`CTG_LOAD_BIT];
    end
  end

  // ---------------- read channel ----------------

  assign axi_rsp.arready = !rvalid;
  assign axi_rsp.rvalid  = rvalid;
  assign axi_rsp.rdata   = rdata;
  assign axi_rsp.rresp   = rresp;

  assign rd_fire = axi_req.arvalid && axi_rsp.arready;
  assign rd_idx  = axi_req.araddr[AW-1:2];

  // live state: pin level, divider waiting, selected source, divisor in use
  assign status_word = {16'h0000,
                        2'b00, active_div,
                        4'h0, sel_ok, sel_now, div_waiting, tx_clk_out};

  // one read at a time; data is registered with its valid
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `CTG_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp  <= `CTG_RESP_OKAY;
      case (rd_idx)
        `CTG_IDX_IRQ2_EN: begin
          rdata <= {16'h0000, irq2_en};
        end
        `CTG_IDX_TXA_GEN: begin
          rdata <= {16'h0000, 16'(gen)};
        end
        `CTG_IDX_STATUS: begin
          rdata <= status_word;
        end
        default: begin
          rdata <= '0;
          rresp <= `CTG_RESP_SLVERR;
        end
      endcase
    end else if (axi_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- source selection ----------------

  // every source pin is foreign to mclk; the third stage only feeds edge detection
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
        sync_c[i] <= 1'b0;
      end else begin
        sync_a[i] <= source_pins[i];
        sync_b[i] <= sync_a[i];
        sync_c[i] <= sync_b[i];
      end
    end
  end

  // code 111 selects nothing and the divider sees a quiet line
  assign sel_ok   = (gen.src <= `CTG_SRC_MEM);
  assign sel_now  = sel_ok ? sync_b[gen.src] : 1'b0;
  assign sel_prev = sel_ok ? sync_c[gen.src] : 1'b0;
  assign src_rise = sel_now && !sel_prev;
  assign src_fall = !sel_now && sel_prev;

  // the divider counts source edges on mclk, so sources must stay well below 50 mhz
  ctg_divider #(
    .DIV_W      (DIV_W)
  ) u_divider (
    .mclk       (mclk),
    .rstn       (rstn),
    .run        (gen.div_run),
    .load_now   (load_pulse),
    .div_new    (gen.div),
    .src_level  (sel_now),
    .src_rise   (src_rise),
    .src_fall   (src_fall),
    .clk_level  (div_clk),
    .active_div (active_div),
    .waiting    (div_waiting)
  );

  // ---------------- pin drive ----------------

  // registered so the pin never sees combinational hazards of the mux
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_clk_out <= 1'b0;
    end else begin
      tx_clk_out <= div_clk ^ gen.inv;
    end
  end

  // enable follows the register bit; the present bit is software bookkeeping only
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_clk_oe <= 1'b0;
    end else begin
      tx_clk_oe <= gen.oe;
    end
  end

endmodule
`default_nettype wire

// ===== tb/ctg_clock_gen_asserts.sv
// port assertions of the port tx clock generator
`timescale 1ns/1ps
`default_nettype none
module ctg_clock_gen_asserts #(
  parameter int NUM_SRC = 7,
  parameter int DIV_W   = 6
) (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  rstn,
  // watched ports
  input wire ctg_pkg::ctg_axi_req_t axi_req,
  input wire ctg_pkg::ctg_axi_rsp_t axi_rsp,
  input wire logic [NUM_SRC-1:0]    source_pins,
  input wire logic                  tx_clk_out,
  input wire logic                  tx_clk_oe
);
  import ctg_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // answers stand until the master takes them
  property p_b_hold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  // both halves are held for one edge before the response is raised
  property p_b_resp;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid;
  endproperty
  a_b_resp: assert property (p_b_resp) else $error("write response late");
  property p_r_resp;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_r_resp: assert property (p_r_resp) else $error("read data late");
  // no new request while an answer is pending
  property p_aw_block;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_ar_block;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during response");
  // registers are 16 bits wide, and a read of an unmapped address is refused with slverr and zero data
  property p_upper;
    axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_unmapped;
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 14'h0004
      |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  // main scenarios reached
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_read: cover property (axi_rsp.rvalid && axi_req.rready);
  c_clk: cover property ($rose(tx_clk_out) && tx_clk_oe);
endmodule
`default_nettype wire

// ===== tb/ctg_partner.sv
// far side: source clocks and a receiver that times the port clock pin
`timescale 1ns/1ps
`default_nettype none
module ctg_partner (
  // source clocks
  output logic [6:0] source_pins,
  // port clock pin
  input  wire logic  tx_clk_out,
  input  wire logic  tx_clk_oe,
  // timings in ns and a count of rising edges
  output var int     per_ns,
  output var int     high_ns,
  output var int     rises,
  output var int     min_w
);
  realtime t_rise;
  // pull-down holds the pin low while it is not driven
  wire logic pin = tx_clk_oe & tx_clk_out;

  // source i: period 100+20*i ns, high 30 ns, so a lost duty cycle shows
  for (genvar i = 0; i < 7; i++) begin : g_src
    initial begin
      source_pins[i] = 1'b0;
      #(3 + i);
      forever begin
        source_pins[i] = 1'b1;
        #30;
        source_pins[i] = 1'b0;
        #(70 + 20 * i);
      end
    end
  end

  // receiver timing, pin edges land on mclk edges
  initial begin
    per_ns = 0;
    high_ns = 0;
    rises = 0;
    min_w = 1000;
    t_rise = 0;
  end
  always @(posedge pin) begin
    per_ns = int'($realtime - t_rise);
    t_rise = $realtime;
    rises = rises + 1;
  end
  always @(negedge pin) begin
    high_ns = int'($realtime - t_rise);
    if (high_ns < min_w) min_w = high_ns;
  end
endmodule
`default_nettype wire

// ===== tb/tb_cell_port_tx_clock_generator.sv
// self-checking bench of the port tx clock generator
`timescale 1ns/1ps
`default_nettype none
`include "ctg_map.svh"
module tb_cell_port_tx_clock_generator;
  import ctg_pkg::*;
  localparam logic [13:0] A_IRQ = 14'(`CTG_IDX_IRQ2_EN * 4);
  localparam logic [13:0] A_GEN = 14'(`CTG_IDX_TXA_GEN * 4);
  logic            mclk;
  logic            rstn;
  ctg_axi_req_t    req;
  ctg_axi_rsp_t    rsp;
  wire logic [6:0] src;
  wire logic       tx_out;
  wire logic       tx_oe;
  int              per_ns, high_ns, rises, min_w, n;
  int              fail_count, tests_run;
  logic [31:0]     seed;
  logic [33:0]     exp_q[$];
  logic [5:0]      dv[4] = '{6'h03, 6'h04, 6'h05, 6'h00};

  ctg_clock_gen #(.NUM_SRC(7), .DIV_W(6)) DUT (.mclk(mclk), .rstn(rstn), .axi_req(req),
    .axi_rsp(rsp), .source_pins(src), .tx_clk_out(tx_out), .tx_clk_oe(tx_oe));
  ctg_partner u_far (.source_pins(src), .tx_clk_out(tx_out), .tx_clk_oe(tx_oe),
    .per_ns(per_ns), .high_ns(high_ns), .rises(rises), .min_w(min_w));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // oe is always set here; clearing it is its own scenario
  function automatic logic [15:0] cfg(input logic [5:0] d, input logic [2:0] s,
                                      input logic inv, run, pres, ld);
    return {2'b00, run, pres, 1'b1, s, inv, ld, d};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pin timing is quantised to mclk, so allow one period either way
  task automatic near(input int got, input int exp);
    tests_run++;
    if (got < exp - 10 || got > exp + 10) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    int k;
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'h3;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      k++;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] a, input logic [15:0] v, input logic [1:0] r = 2'h0);
    int k;
    exp_q.push_back({r, 16'h0000, v});
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      k++;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    req.rready <= 1'b0;
  endtask
  // restart the divider around a new setting so no stale pulse is timed
  task automatic go(input logic [5:0] d, input logic [2:0] s, input logic inv, pres, ld);
    wr(A_GEN, cfg(d, s, inv, 1'b0, pres, 1'b0));
    wr(A_GEN, cfg(d, s, inv, 1'b1, pres, ld));
  endtask
  task automatic meas(input int eper, input int ehigh);
    int r0;
    r0 = rises;
    for (int k = 0; k < 20000 && rises < r0 + 3; k++) @(posedge mclk);
    near(per_ns, eper);
    near(high_ns, ehigh);
  endtask
  task automatic results;
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // read results are checked in order as they appear
  always @(posedge mclk) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
  end
  // a hang ends the run as a mismatch
  initial begin
    #200000;
    fail_count++;
    results();
  end
  // main sequence
  initial begin
    req = '0;
    rstn = 1'b0;
    fail_count = 0;
    tests_run = 0;
    seed = 32'h26f19d5e;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(A_IRQ, 16'h0000);
    rd(A_GEN, 16'h0403);
    chk({33'h0, tx_oe}, 34'h0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      wr(A_IRQ, seed[15:0]);
      rd(A_IRQ, seed[15:0]);
    end
    rd(14'h0004, 16'h0000, 2'h2);
    wr(A_GEN, cfg(6'h02, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    rd(A_GEN, cfg(6'h02, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (40) @(posedge mclk) chk({33'h0, tx_out}, 34'h0);
    for (int s = 0; s < 7; s++) begin
      go(6'h01, s[2:0], 1'b0, 1'b1, 1'b0);
      meas(100 + 20 * s, 30);
    end
    go(6'h02, 3'h0, 1'b0, 1'b1, 1'b0);
    meas(200, 100);
    u_far.min_w = 1000;
    foreach (dv[i]) begin
      wr(A_GEN, cfg(dv[i], 3'h0, 1'b0, 1'b1, 1'b1, 1'b0));
      n = (dv[i] == 6'h00) ? 1 : int'(dv[i]);
      meas(n * 100, ((n + 1) / 2) * 30 + (n / 2) * 70);
    end
    chk({33'h0, min_w >= 20}, 34'h1);
    go(6'h01, 3'h0, 1'b1, 1'b1, 1'b0);
    meas(100, 70);
    go(6'h03, 3'h0, 1'b0, 1'b0, 1'b1);
    meas(300, 130);
    wr(A_GEN, cfg(6'h03, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0) & 16'hf7ff);
    repeat (2) @(posedge mclk);
    chk({33'h0, tx_oe}, 34'h0);
    results();
  end
endmodule

bind ctg_clock_gen ctg_clock_gen_asserts #(.NUM_SRC(NUM_SRC), .DIV_W(DIV_W)) u_chk (
  .mclk(mclk), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .source_pins(source_pins), .tx_clk_out(tx_clk_out), .tx_clk_oe(tx_clk_oe));
`default_nettype wire
